// ### design/xpc_pkg.sv
package xpc_pkg;

	// ==========================================================
	// sizes
	localparam int GROUP_W   = 20;
	localparam int IDX_W     = 5;
	localparam int RING_LEN  = 80;
	localparam int POS_W     = 7;
	localparam int MUX_N     = 4;
	localparam int DCLK_N    = 2;
	localparam int GCE_N     = 2;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;

	// ==========================================================
	// register offsets
	localparam logic [ADDR_W-1:0] OFF_MUX   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SEL   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STORE = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_OUT   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_STAT  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_RING  = 8'h14;

	// ==========================================================
	// select codes, high bit first
	localparam logic [1:0] SEL_CODE_IN0 = 2'h0;
	localparam logic [1:0] SEL_CODE_IN1 = 2'h1;
	localparam logic [1:0] SEL_CODE_IN2 = 2'h3;
	localparam logic [1:0] SEL_CODE_IN3 = 2'h2;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		XPC_BYPASS,
		XPC_LATCH,
		XPC_REG
	} xpc_store_mode_t;

	typedef struct packed {
		logic [MUX_N-1:0]            casc_en;
		logic [MUX_N-1:0][IDX_W-1:0] dir_idx;
	} xpc_mux_cfg_t;

	typedef struct packed {
		logic             lo_set2;
		logic             hi_set2;
		logic [IDX_W-1:0] lo_idx;
		logic [IDX_W-1:0] hi_idx;
		logic             lo_pol;
		logic             hi_pol;
	} xpc_sel_cfg_t;

	typedef struct packed {
		logic [1:0]       mode;
		logic             place_in;
		logic             comb;
		logic             clk_ded;
		logic [IDX_W-1:0] clk_idx;
		logic             clk_pol;
		logic             ce_glob;
		logic [IDX_W-1:0] ce_idx;
		logic             ce_pol;
	} xpc_store_cfg_t;

	typedef struct packed {
		logic             out_pol;
		logic             open_drain;
		logic             bus_hold;
		logic             const_en;
		logic             const_val;
		logic [IDX_W-1:0] oe_idx;
		logic             oe_pol;
	} xpc_out_cfg_t;

	localparam int MUX_CFG_W   = $bits(xpc_mux_cfg_t);
	localparam int SEL_CFG_W   = $bits(xpc_sel_cfg_t);
	localparam int STORE_CFG_W = $bits(xpc_store_cfg_t);
	localparam int OUT_CFG_W   = $bits(xpc_out_cfg_t);

	// ==========================================================
	// values after reset
	localparam xpc_mux_cfg_t   RST_MUX   = '0;
	localparam xpc_sel_cfg_t   RST_SEL   = '0;
	localparam xpc_store_cfg_t RST_STORE = '0;
	localparam xpc_out_cfg_t   RST_OUT   = '0;

endpackage

// ### design/xpc_mux.sv
module xpc_mux (
	input  wire logic                   clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic [xpc_pkg::MUX_N-1:0] direct_i,
	input  wire logic [xpc_pkg::MUX_N-1:0] casc_i,
	input  wire logic [xpc_pkg::MUX_N-1:0] casc_en_i,
	input  wire logic                   reflected_i,
	input  wire logic [1:0]             sel_i,
	output logic                        mux_o
);

	// ==========================================================
	// cascade substitution
	logic [xpc_pkg::MUX_N-1:0] mapped;
	logic [xpc_pkg::MUX_N-1:0] data;

	for (genvar k = 0; k < xpc_pkg::MUX_N; k++) begin : g_in
		// normal order n-2,n-1,n+1,n+2, reflected reversed
		assign mapped[k] = reflected_i ? casc_i[xpc_pkg::MUX_N-1-k]
		                               : casc_i[k];
		// neighbour takes the direct group's slot
		assign data[k] = casc_en_i[k] ? mapped[k] : direct_i[k];
	end

	// ==========================================================
	// gray coded select
	always_comb begin
		unique case (sel_i)
			xpc_pkg::SEL_CODE_IN0: mux_o = data[0];
			xpc_pkg::SEL_CODE_IN1: mux_o = data[1];
			xpc_pkg::SEL_CODE_IN2: mux_o = data[2];
			xpc_pkg::SEL_CODE_IN3: mux_o = data[3];
		endcase
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_gray_code_in3: assert property (
		sel_i == 2'h2 && !casc_en_i[3] |-> mux_o == direct_i[3])
		else $error("select 10 did not forward input three");
	a_gray_code_in2: assert property (
		sel_i == 2'h3 && !casc_en_i[2] |-> mux_o == direct_i[2])
		else $error("select 11 did not forward input two");
	a_casc_order: assert property (
		sel_i == 2'h0 && casc_en_i[0]
		|-> mux_o == (reflected_i ? casc_i[3] : casc_i[0]))
		else $error("cascade order wrong on input zero");
	a_casc_hides_dir: assert property (
		sel_i == 2'h1 && casc_en_i[1] && !reflected_i
		|-> mux_o == casc_i[1])
		else $error("direct group not replaced by neighbour");

endmodule

// ### design/xpc_store.sv
module xpc_store (
	input  wire logic                     clk_i,
	input  wire logic                     rst_n_i,
	input  xpc_pkg::xpc_store_mode_t      mode_i,
	input  wire logic                     d_i,
	input  wire logic                     clk_lvl_i,
	input  wire logic                     ce_i,
	output logic                          q_o
);

	// ==========================================================
	// edge detect on the selected clock level
	logic lvl_q;
	logic hold_q;
	logic rise;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lvl_q <= 1'b0;
		end else begin
			lvl_q <= clk_lvl_i;
		end
	end

	assign rise = clk_lvl_i && !lvl_q;

	// ==========================================================
	// storage element
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_q <= 1'b0;
		end else begin
			unique case (mode_i)
				xpc_pkg::XPC_LATCH: if (clk_lvl_i) begin
					hold_q <= d_i;
				end
				xpc_pkg::XPC_REG: if (rise && ce_i) begin
					hold_q <= d_i;
				end
				default: hold_q <= d_i;
			endcase
		end
	end

	always_comb begin
		unique case (mode_i)
			xpc_pkg::XPC_LATCH: q_o = clk_lvl_i ? d_i : hold_q;
			xpc_pkg::XPC_REG:   q_o = hold_q;
			default:            q_o = d_i;
		endcase
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_reg_edge;
		mode_i == xpc_pkg::XPC_REG && !lvl_q && clk_lvl_i && ce_i;
	endsequence

	sequence s_reg_idle;
		mode_i == xpc_pkg::XPC_REG && !ce_i;
	endsequence

	a_reg_capture: assert property (
		s_reg_edge |=> q_o == $past(d_i))
		else $error("register missed an enabled clock edge");
	a_reg_ce_hold: assert property (
		s_reg_idle ##1 s_reg_idle |-> $stable(q_o))
		else $error("register changed with clock enable low");
	a_latch_open: assert property (
		mode_i == xpc_pkg::XPC_LATCH && clk_lvl_i |-> q_o == d_i)
		else $error("latch not transparent");
	a_latch_shut: assert property (
		mode_i == xpc_pkg::XPC_LATCH && !clk_lvl_i
		##1 mode_i == xpc_pkg::XPC_LATCH && !clk_lvl_i |-> $stable(q_o))
		else $error("closed latch changed");

endmodule

// ### design/xpc_cell.sv
// Function
// - select 00,01,11,10 forwards data input zero, one, two, three
// - each select bit takes its pin from either select pin set
// - neighbour cascade outputs two above and two below may be chosen
// - a chosen neighbour replaces that data input's direct pin group
// - normal order n-2,n-1,n+1,n+2 for A-D; reflected order reversed
// - ring positions split into a normal half and a reflected half
// - neighbour numbering wraps around the cell ring
// - storage element works as latch, register or bypass
// - output placement: mux feeds storage, storage drives the pin
// - input placement: pin feeds storage, storage drives routing pool
// - combinatorial bit routes mux result around storage to the pin
// - clock from clock set pin or dedicated pin, polarity selectable
// - clock enable from clock set pin or global pin, polarity selectable
// - final output active high or active low
// - open drain output drives low only, releases otherwise
// - bus hold keeps last level when every driver is off
// - clock enable low makes register ignore clock edges
// - output enable from enable pin set with polarity, else tri-state
// - constant high or low drive independent of inputs
//
// Decided for this implementation: the strobed register port and the placing of the registers.
module xpc_cell #(
	parameter int GROUP_W  = xpc_pkg::GROUP_W,
	parameter int RING_LEN = xpc_pkg::RING_LEN,
	parameter int CELL_POS = 0
) (
	input  wire logic                               CLK_I,
	input  wire logic                               RST_N_I,
	input  wire logic [xpc_pkg::ADDR_W-1:0]         REG_ADDR_I,
	input  wire logic [xpc_pkg::DATA_W-1:0]         REG_WDATA_I,
	input  wire logic                               REG_WR_I,
	input  wire logic                               REG_RD_I,
	output logic      [xpc_pkg::DATA_W-1:0]         REG_RDATA_O,
	input  wire logic [xpc_pkg::MUX_N-1:0][GROUP_W-1:0] DIRECT_I,
	input  wire logic [GROUP_W-1:0]                 SELECT_PIN_SET_ONE_I,
	input  wire logic [GROUP_W-1:0]                 SELECT_PIN_SET_TWO_I,
	input  wire logic [GROUP_W-1:0]                 CLK_SET_I,
	input  wire logic [GROUP_W-1:0]                 OE_SET_I,
	input  wire logic [xpc_pkg::DCLK_N-1:0]         DEDICATED_CLOCK_PIN_I,
	input  wire logic [xpc_pkg::GCE_N-1:0]          GLOBAL_CLOCK_ENABLE_PIN_I,
	input  wire logic [xpc_pkg::MUX_N-1:0]          CASCADE_I,
	output logic                                    CASCADE_OUTPUT_O,
	output logic                                    GLOBAL_ROUTING_POOL_O,
	input  wire logic                               PIN_I,
	output logic                                    PIN_O,
	output logic                                    PIN_OE_O,
	output logic                                    KEEP_O,
	output logic                                    KEEP_OE_O
);

	// ==========================================================
	// ring position of this cell and its neighbours
	localparam logic REFLECTED = (CELL_POS >= RING_LEN / 2);

	function automatic logic [xpc_pkg::POS_W-1:0] ring_pos(input int ofs);
		int p;
		p = (CELL_POS + ofs + RING_LEN) % RING_LEN;
		return p[xpc_pkg::POS_W-1:0];
	endfunction

	localparam logic [xpc_pkg::POS_W-1:0] POS_M2 = ring_pos(-2);
	localparam logic [xpc_pkg::POS_W-1:0] POS_M1 = ring_pos(-1);
	localparam logic [xpc_pkg::POS_W-1:0] POS_P1 = ring_pos(1);
	localparam logic [xpc_pkg::POS_W-1:0] POS_P2 = ring_pos(2);

	function automatic logic pick(input logic [GROUP_W-1:0] v,
	                              input logic [xpc_pkg::IDX_W-1:0] i);
		logic r;
		r = 1'b0;
		if (int'(i) < GROUP_W) begin
			r = v[i];
		end
		return r;
	endfunction

	// ==========================================================
	// configuration registers
	xpc_pkg::xpc_mux_cfg_t   mux_cfg_q;
	xpc_pkg::xpc_sel_cfg_t   sel_cfg_q;
	xpc_pkg::xpc_store_cfg_t store_cfg_q;
	xpc_pkg::xpc_out_cfg_t   out_cfg_q;
	logic [xpc_pkg::DATA_W-1:0] rdata_q;
	logic [xpc_pkg::DATA_W-1:0] rdata_d;
	logic                       keep_q;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			mux_cfg_q <= xpc_pkg::RST_MUX;
		end else if (REG_WR_I && REG_ADDR_I == xpc_pkg::OFF_MUX) begin
			mux_cfg_q <= REG_WDATA_I[xpc_pkg::MUX_CFG_W-1:0];
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sel_cfg_q <= xpc_pkg::RST_SEL;
		end else if (REG_WR_I && REG_ADDR_I == xpc_pkg::OFF_SEL) begin
			sel_cfg_q <= REG_WDATA_I[xpc_pkg::SEL_CFG_W-1:0];
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			store_cfg_q <= xpc_pkg::RST_STORE;
		end else if (REG_WR_I && REG_ADDR_I == xpc_pkg::OFF_STORE) begin
			store_cfg_q <= REG_WDATA_I[xpc_pkg::STORE_CFG_W-1:0];
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			out_cfg_q <= xpc_pkg::RST_OUT;
		end else if (REG_WR_I && REG_ADDR_I == xpc_pkg::OFF_OUT) begin
			out_cfg_q <= REG_WDATA_I[xpc_pkg::OUT_CFG_W-1:0];
		end
	end

	// ==========================================================
	// select lines
	logic       sel_lo;
	logic       sel_hi;
	logic [1:0] sel;

	always_comb begin
		// either pin set may serve either select bit
		sel_lo = sel_cfg_q.lo_set2
			? pick(SELECT_PIN_SET_TWO_I, sel_cfg_q.lo_idx)
			: pick(SELECT_PIN_SET_ONE_I, sel_cfg_q.lo_idx);
		sel_hi = sel_cfg_q.hi_set2
			? pick(SELECT_PIN_SET_TWO_I, sel_cfg_q.hi_idx)
			: pick(SELECT_PIN_SET_ONE_I, sel_cfg_q.hi_idx);
		sel_lo = sel_lo ^ sel_cfg_q.lo_pol;
		sel_hi = sel_hi ^ sel_cfg_q.hi_pol;
	end

	assign sel = {sel_hi, sel_lo};

	// ==========================================================
	// data multiplexer
	logic [xpc_pkg::MUX_N-1:0] direct;
	logic                      mux_out;

	for (genvar k = 0; k < xpc_pkg::MUX_N; k++) begin : g_dir
		assign direct[k] = pick(DIRECT_I[k], mux_cfg_q.dir_idx[k]);
	end

	xpc_mux u_mux (
		.clk_i       (CLK_I),
		.rst_n_i     (RST_N_I),
		.direct_i    (direct),
		.casc_i      (CASCADE_I),
		.casc_en_i   (mux_cfg_q.casc_en),
		.reflected_i (REFLECTED),
		.sel_i       (sel),
		.mux_o       (mux_out)
	);

	assign CASCADE_OUTPUT_O = mux_out;

	// ==========================================================
	// clock and clock enable sources
	logic clk_lvl;
	logic ce;

	always_comb begin
		clk_lvl = store_cfg_q.clk_ded
			? DEDICATED_CLOCK_PIN_I[store_cfg_q.clk_idx[0]]
			: pick(CLK_SET_I, store_cfg_q.clk_idx);
		clk_lvl = clk_lvl ^ store_cfg_q.clk_pol;
		ce = store_cfg_q.ce_glob
			? GLOBAL_CLOCK_ENABLE_PIN_I[store_cfg_q.ce_idx[0]]
			: pick(CLK_SET_I, store_cfg_q.ce_idx);
		ce = ce ^ store_cfg_q.ce_pol;
	end

	// ==========================================================
	// storage element and its placement
	xpc_pkg::xpc_store_mode_t store_mode;
	logic                     store_d;
	logic                     store_q;

	assign store_mode = (store_cfg_q.mode == 2'h3) ? xpc_pkg::XPC_BYPASS
		: xpc_pkg::xpc_store_mode_t'(store_cfg_q.mode);
	// input path from the pin, output path from the mux
	assign store_d = store_cfg_q.place_in ? PIN_I : mux_out;

	xpc_store u_store (
		.clk_i     (CLK_I),
		.rst_n_i   (RST_N_I),
		.mode_i    (store_mode),
		.d_i       (store_d),
		.clk_lvl_i (clk_lvl),
		.ce_i      (ce),
		.q_o       (store_q)
	);

	// routing pool sees stored pin in input placement
	assign GLOBAL_ROUTING_POOL_O = store_cfg_q.place_in ? store_q : PIN_I;

	// ==========================================================
	// output path
	logic path_out;
	logic final_out;
	logic oe_eff;

	always_comb begin
		// stored value to the pin unless bypassed or in input placement
		path_out = (!store_cfg_q.place_in && !store_cfg_q.comb)
			? store_q : mux_out;
		final_out = out_cfg_q.const_en ? out_cfg_q.const_val
			: path_out ^ out_cfg_q.out_pol;
		oe_eff = out_cfg_q.const_en
			| (pick(OE_SET_I, out_cfg_q.oe_idx) ^ out_cfg_q.oe_pol);
	end

	// open drain never drives high
	assign PIN_O    = out_cfg_q.open_drain ? 1'b0 : final_out;
	assign PIN_OE_O = oe_eff && (!out_cfg_q.open_drain || !final_out);

	// ==========================================================
	// bus keeper
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			keep_q <= 1'b0;
		end else begin
			keep_q <= PIN_I;
		end
	end

	assign KEEP_O    = keep_q;
	assign KEEP_OE_O = out_cfg_q.bus_hold && !PIN_OE_O;

	// ==========================================================
	// register read
	always_comb begin
		rdata_d = '0;
		if (REG_RD_I) begin
			unique case (REG_ADDR_I)
				xpc_pkg::OFF_MUX:   rdata_d[xpc_pkg::MUX_CFG_W-1:0] = mux_cfg_q;
				xpc_pkg::OFF_SEL:   rdata_d[xpc_pkg::SEL_CFG_W-1:0] = sel_cfg_q;
				xpc_pkg::OFF_STORE:
					rdata_d[xpc_pkg::STORE_CFG_W-1:0] = store_cfg_q;
				xpc_pkg::OFF_OUT:   rdata_d[xpc_pkg::OUT_CFG_W-1:0] = out_cfg_q;
				xpc_pkg::OFF_STAT:  rdata_d[9:0] = {ce, clk_lvl, sel, REFLECTED,
					PIN_I, PIN_OE_O, final_out, store_q, mux_out};
				xpc_pkg::OFF_RING:  rdata_d[27:0] = {POS_P2, POS_P1, POS_M1,
					POS_M2};
				default:            rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign REG_RDATA_O = rdata_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	a_oe_inactive: assert property (
		!out_cfg_q.const_en
		&& !(pick(OE_SET_I, out_cfg_q.oe_idx) ^ out_cfg_q.oe_pol)
		|-> !PIN_OE_O)
		else $error("pin driven with enable inactive");
	a_open_drain: assert property (
		out_cfg_q.open_drain |-> !PIN_O && (PIN_OE_O == (oe_eff && !final_out)))
		else $error("open drain drove high");
	a_const_level: assert property (
		out_cfg_q.const_en && !out_cfg_q.open_drain
		|-> PIN_OE_O && PIN_O == out_cfg_q.const_val)
		else $error("constant level not driven");
	a_out_polarity: assert property (
		!out_cfg_q.const_en && store_cfg_q.comb && !out_cfg_q.open_drain
		&& !store_cfg_q.place_in |-> PIN_O == (mux_out ^ out_cfg_q.out_pol))
		else $error("output polarity wrong");
	a_in_path_pool: assert property (
		store_cfg_q.place_in && store_mode == xpc_pkg::XPC_BYPASS
		|-> GLOBAL_ROUTING_POOL_O == PIN_I)
		else $error("routing pool lost the pin");
	a_reg_out_delay: assert property (
		!store_cfg_q.place_in && !store_cfg_q.comb && !out_cfg_q.const_en
		&& store_mode == xpc_pkg::XPC_REG && !out_cfg_q.open_drain
		&& $stable(store_cfg_q) && $stable(out_cfg_q)
		&& !($past(clk_lvl) && !$past(clk_lvl, 2))
		|-> $stable(PIN_O))
		else $error("registered output moved without a clock edge");
	a_rdata_window: assert property (
		!REG_RD_I |=> REG_RDATA_O == '0)
		else $error("read data outside its cycle");
	a_stat_read: assert property (
		REG_RD_I && REG_ADDR_I == xpc_pkg::OFF_STAT
		|=> REG_RDATA_O[4] == $past(PIN_I) && REG_RDATA_O[5] == REFLECTED)
		else $error("status read wrong");
	a_keeper: assert property (
		out_cfg_q.bus_hold && !PIN_OE_O ##1 1'b1 |-> KEEP_O == $past(PIN_I))
		else $error("keeper lost the last level");

endmodule

// ### verification/xpc_sel_model.sv
module xpc_sel_model (
	input  wire logic                         clk_i,
	input  wire logic [1:0]                   code_i,
	output logic      [xpc_pkg::GROUP_W-1:0]  set_one_o,
	output logic      [xpc_pkg::GROUP_W-1:0]  set_two_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [xpc_pkg::GROUP_W-1:0] noise_q = 20'h5A5A5;

	// ==========================================================
	// select drive, unused pins change every cycle
	always_ff @(posedge clk_i) begin
		noise_q      <= {noise_q[18:0], noise_q[19] ^ noise_q[16]};
		set_one_o <= {noise_q[19:4], code_i[0], noise_q[2:0]};
		set_two_o <= {~noise_q[19:6], code_i[1], ~noise_q[4:0]};
	end
endmodule

// ### verification/xpc_cell_test.sv
module xpc_cell_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic             clk = 1'h0;
	logic             rst_n = 1'h0;
	logic [7:0]       addr = 8'h00;
	logic [31:0]      wdata = 32'h0;
	logic             wr = 1'h0;
	logic             rd = 1'h0;
	logic [31:0]      rdata;
	logic [3:0][19:0] dir = '0;
	logic [19:0]      set1;
	logic [19:0]      set2;
	logic [19:0]      clkset = 20'h0;
	logic [19:0]      oeset = 20'hFFFFF;
	logic [1:0]       dclk = 2'h3;
	logic [1:0]       gce = 2'h1;
	logic [3:0]       casc = 4'h0;
	logic [1:0]       code = 2'h0;
	logic             pin_i = 1'h0;
	logic             pin_o;
	logic             pin_oe;
	logic             keep;
	logic             keep_oe;
	logic             casc_o;
	logic             pool;
	int               errors = 0;
	int               n_checks = 0;

	// ==========================================================
	// design and select driver
	xpc_cell #(.CELL_POS(0)) xpc_cell_inst (
		.CLK_I                     (clk),
		.RST_N_I                   (rst_n),
		.REG_ADDR_I                (addr),
		.REG_WDATA_I               (wdata),
		.REG_WR_I                  (wr),
		.REG_RD_I                  (rd),
		.REG_RDATA_O               (rdata),
		.DIRECT_I                  (dir),
		.SELECT_PIN_SET_ONE_I      (set1),
		.SELECT_PIN_SET_TWO_I      (set2),
		.CLK_SET_I                 (clkset),
		.OE_SET_I                  (oeset),
		.DEDICATED_CLOCK_PIN_I     (dclk),
		.GLOBAL_CLOCK_ENABLE_PIN_I (gce),
		.CASCADE_I                 (casc),
		.CASCADE_OUTPUT_O          (casc_o),
		.GLOBAL_ROUTING_POOL_O     (pool),
		.PIN_I                     (pin_i),
		.PIN_O                     (pin_o),
		.PIN_OE_O                  (pin_oe),
		.KEEP_O                    (keep),
		.KEEP_OE_O                 (keep_oe)
	);

	xpc_sel_model xpc_sel_model_inst (
		.clk_i     (clk),
		.code_i    (code),
		.set_one_o (set1),
		.set_two_o (set2)
	);

	always #2.5 clk = ~clk;

	// ==========================================================
	// helpers
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr    <= 1'h1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
		#1;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd   <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1 d = rdata;
	endtask

	task automatic edge_pair(input logic [19:0] lo, input logic [19:0] hi);
		clkset <= lo;
		cyc(1);
		clkset <= hi;
		cyc(1);
	endtask

	function automatic logic exp_mux(input logic [1:0] c, input logic [3:0] en);
		int k;
		k = (c == 2'h0) ? 0 : (c == 2'h1) ? 1 : (c == 2'h3) ? 2 : 3;
		return en[k] ? casc[k] : dir[k][k + 1];
	endfunction

	function automatic logic [2:0] exp_pin(input logic [10:0] w, input logic m);
		logic fin;
		logic oe;
		logic o;
		fin = w[7] ? w[6] : m ^ w[10];
		oe  = w[7] ? 1'h1 : oeset[w[5:1]] ^ w[0];
		o   = fin;
		if (w[9]) begin
			o  = 1'h0;
			oe = oe & ~fin;
		end
		return {oe, o, ~oe & w[8]};
	endfunction

	task automatic complete_run();
		$display("errors=%0d checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#(5 * 20000);
		errors++;
		complete_run();
	end

	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] v;
		logic [3:0]  en;
		logic [1:0]  c;
		logic [10:0] w;
		void'($urandom(34330));
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		rd_reg(xpc_pkg::OFF_OUT, v);
		check("out reset", v, 32'h0);
		rd_reg(8'hFC, v);
		check("unmapped", v, 32'h0);
		wr_reg(xpc_pkg::OFF_RING, 32'hFFFFFFFF);
		rd_reg(xpc_pkg::OFF_RING, v);
		check("ring", v, {4'h0, 7'h2, 7'h1, 7'h4F, 7'h4E});
		rd_reg(xpc_pkg::OFF_STAT, v);
		check("reflected", 32'(v[5]), 32'h0);
		wr_reg(xpc_pkg::OFF_SEL, {18'h0, 1'h0, 1'h1, 5'h3, 5'h5, 2'h0});
		for (int i = 0; i < 40; i++) begin
			en = (i < 4) ? 4'h0 : 4'($urandom);
			wr_reg(xpc_pkg::OFF_MUX, {8'h0, en, 5'h4, 5'h3, 5'h2, 5'h1});
			c = (i < 4) ? 2'(i) : 2'($urandom);
			code <= c;
			casc <= 4'($urandom);
			for (int k = 0; k < 4; k++)
				dir[k] <= 20'($urandom);
			cyc(2);
			check("mux", 32'(casc_o),
				32'(exp_mux(c, en)));
		end
		wr_reg(xpc_pkg::OFF_MUX, {8'h0, 4'h0, 5'h4, 5'h3, 5'h2, 5'h1});
		code <= 2'h0;
		for (int i = 0; i < 24; i++) begin
			w = 11'($urandom);
			w[5:1] = 5'(w[5:1] % 20);
			oeset <= 20'($urandom);
			dir[0][1] <= i[0];
			wr_reg(xpc_pkg::OFF_OUT, {21'h0, w});
			check("pins", 32'({pin_oe, pin_o, keep_oe}),
				32'(exp_pin(w, i[0])));
			rd_reg(xpc_pkg::OFF_OUT, v);
			check("out readback", v, {21'h0, w});
		end
		// register mode from clock set pin
		wr_reg(xpc_pkg::OFF_OUT, 32'h0);
		oeset <= 20'hFFFFF;
		dir[0][1] <= 1'h0;
		clkset <= 20'h00040;
		wr_reg(xpc_pkg::OFF_STORE, {14'h0, 2'h2, 3'h0, 5'h4, 2'h0, 5'h6, 1'h0});
		check("reg idle", 32'(pin_o), 32'h0);
		dir[0][1] <= 1'h1;
		cyc(2);
		check("reg no edge", 32'(pin_o), 32'h0);
		edge_pair(20'h00040, 20'h00050);
		check("reg capture", 32'(pin_o), 32'h1);
		dir[0][1] <= 1'h0;
		cyc(2);
		check("reg hold", 32'(pin_o), 32'h1);
		edge_pair(20'h00000, 20'h00010);
		check("ce low", 32'(pin_o), 32'h1);
		edge_pair(20'h00040, 20'h00050);
		check("ce high", 32'(pin_o), 32'h0);
		// dedicated clock, inverted, global enable
		dir[0][1] <= 1'h1;
		wr_reg(xpc_pkg::OFF_STORE, {14'h0, 2'h2, 3'h1, 5'h1, 2'h3, 5'h0, 1'h0});
		cyc(1);
		dclk <= 2'h1;
		cyc(1);
		check("dedicated clk", 32'(pin_o), 32'h1);
		// latch mode
		wr_reg(xpc_pkg::OFF_STORE, {14'h0, 2'h1, 3'h0, 5'h4, 2'h0, 5'h6, 1'h0});
		clkset <= 20'h00010;
		dir[0][1] <= 1'h0;
		cyc(2);
		check("latch open", 32'(pin_o), 32'h0);
		clkset <= 20'h00000;
		cyc(2);
		dir[0][1] <= 1'h1;
		cyc(2);
		check("latch shut", 32'(pin_o), 32'h0);
		wr_reg(xpc_pkg::OFF_STORE, {14'h0, 2'h2, 3'h2, 5'h4, 2'h0, 5'h6, 1'h0});
		check("comb", 32'(pin_o), 32'h1);
		// input placement
		pin_i <= 1'h1;
		wr_reg(xpc_pkg::OFF_STORE, {14'h0, 2'h2, 3'h4, 5'h4, 2'h0, 5'h6, 1'h0});
		edge_pair(20'h00040, 20'h00050);
		check("keeper set", 32'(keep), 32'h1);
		pin_i <= 1'h0;
		cyc(2);
		check("input path", 32'({pool, pin_o}), 32'h3);
		check("keeper", 32'(keep), 32'h0);
		complete_run();
	end
endmodule
